// ### data_alu_defines.vh
// What this block does
// - four 24-bit operand input registers
// - two 56-bit accumulators from three parts
// - pipelined 24x24 multiplier, new product every clock
// - 56-bit barrel shifter, shift and normalize
// - registers reachable over both memory data buses
// - operands only from own registers, sized widths
// - results always land in an accumulator
// - two-cycle pipeline, one instruction per clock
// - back-to-back results forwarded without stall
// - 24-bit or 16-bit arithmetic by mode
// - one shifter/limiter per memory data bus
// - conditional instructions update only when true
// - multiply-accumulate takes three operands, 56-bit result
// - signed/unsigned/mixed fractional product, round or truncate
`ifndef DATA_ALU_DEFINES_VH
`define DATA_ALU_DEFINES_VH

// bus register select codes
`define SEL_FIRST_LO  4'h0
`define SEL_FIRST_HI  4'h1
`define SEL_SECOND_LO 4'h2
`define SEL_SECOND_HI 4'h3
`define SEL_ONE_LOW   4'h4
`define SEL_ONE_HIGH  4'h5
`define SEL_ONE_EXT   4'h6
`define SEL_TWO_LOW   4'h7
`define SEL_TWO_HIGH  4'h8
`define SEL_TWO_EXT   4'h9
`define SEL_ONE_LIM   4'hA
`define SEL_TWO_LIM   4'hB

// arithmetic source operand codes
`define SRC_FIRST_LO  3'h0
`define SRC_FIRST_HI  3'h1
`define SRC_SECOND_LO 3'h2
`define SRC_SECOND_HI 3'h3
`define SRC_ACC_ONE   3'h4
`define SRC_ACC_TWO   3'h5
`define SRC_FIRST_L   3'h6
`define SRC_SECOND_L  3'h7

// operation codes
`define OP_NOP  4'h0
`define OP_MPY  4'h1
`define OP_MAC  4'h2
`define OP_ADD  4'h3
`define OP_SUB  4'h4
`define OP_TFR  4'h5
`define OP_AND  4'h6
`define OP_OR   4'h7
`define OP_EOR  4'h8
`define OP_ASH  4'h9
`define OP_NORM 4'hA
`define OP_CLR  4'hB
`define OP_NEG  4'hC
`define OP_ABS  4'hD

// multiplier operand signedness
`define SGN_SS 2'h0
`define SGN_SU 2'h1
`define SGN_UU 2'h2

// limiter scaling
`define SCALE_NONE 2'h0
`define SCALE_DOWN 2'h1
`define SCALE_UP   2'h2

// reset, limit, rounding and mask values
`define ACC_RESET  56'h00000000000000
`define REG_RESET  24'h000000
`define LIM24_POS  24'h7FFFFF
`define LIM24_NEG  24'h800000
`define LIM16_POS  24'h007FFF
`define LIM16_NEG  24'h008000
`define RND24      56'h00000000800000
`define RND16      56'h00000080000000
`define MASK24     56'hFFFFFFFF000000
`define MASK16     56'hFFFFFF00000000
`define KEEP16     56'hFFFFFFFFFF0000
`define KEEP24     56'hFFFFFFFFFFFFFF
// normalized when exactly nine leading sign bits
`define NORM_LEAD  7'h09

`endif

// ### bus_limiter.v
`timescale 1ns/100ps
`default_nettype none
`include "data_alu_defines.vh"

module bus_limiter (
   // accumulator in
   input wire [55:0] acc,
   input wire [1:0] scale,
   input wire mode16,
   // bus word out
   output reg [23:0] word,
   output reg limited
);

   reg [55:0] scaled;

   always @* begin
      scaled = acc;
      if (scale == `SCALE_DOWN) begin
         scaled = {acc[55], acc[55:1]};
      end else if (scale == `SCALE_UP) begin
         scaled = {acc[54:0], 1'b0};
      end
      // sign bit of the high word must match the whole extension
      limited = !((&scaled[55:47]) || !(|scaled[55:47]));
      if (limited) begin
         if (mode16) begin
            word = scaled[55] ? `LIM16_NEG : `LIM16_POS;
         end else begin
            word = scaled[55] ? `LIM24_NEG : `LIM24_POS;
         end
      end else if (mode16) begin
         word = {8'h00, scaled[47:32]};
      end else begin
         word = scaled[47:24];
      end
   end

endmodule // bus_limiter
`default_nettype wire

// ### data_alu.v
`timescale 1ns/100ps
`default_nettype none
`include "data_alu_defines.vh"

module data_alu (
   // clock and reset
   input wire clk,
   input wire rst,
   // mode and limiter scaling
   input wire mode16,
   input wire [1:0] scale,
   // instruction issue
   input wire op_valid,
   input wire [3:0] op_code,
   input wire [2:0] op_src1,
   input wire [2:0] op_src2,
   input wire op_dst,
   input wire op_cond,
   input wire op_round,
   input wire [1:0] op_sign,
   input wire [6:0] op_amt,
   // first memory data bus
   input wire x_wr_en,
   input wire [3:0] x_wr_sel,
   input wire [23:0] x_wr_data,
   input wire [3:0] x_rd_sel,
   output reg [23:0] x_rd_data_q,
   output reg x_limited_q,
   // second memory data bus
   input wire y_wr_en,
   input wire [3:0] y_wr_sel,
   input wire [23:0] y_wr_data,
   input wire [3:0] y_rd_sel,
   output reg [23:0] y_rd_data_q,
   output reg y_limited_q,
   // result flags
   output reg res_zero_q,
   output reg res_neg_q
);

   ////////////////////////////////////////////////////////////////////
   reg [23:0] input_reg_first_hi_q;
   reg [23:0] input_reg_first_lo_q;
   reg [23:0] input_reg_second_hi_q;
   reg [23:0] input_reg_second_lo_q;
   reg [55:0] acc_one_q;
   reg [55:0] acc_two_q;
   reg [55:0] acc_one_d;
   reg [55:0] acc_two_d;
   // stage one holds decoded op and forwarded operands
   reg s1_valid_q;
   reg [3:0] s1_op_q;
   reg s1_dst_q;
   reg s1_round_q;
   reg [1:0] s1_sign_q;
   reg [6:0] s1_amt_q;
   reg [55:0] s1_opa_q;
   reg [55:0] s1_opb_q;
   reg [55:0] s1_acc_q;
   reg [55:0] res;
   reg [49:0] prod_full;
   reg [55:0] prod;
   reg [6:0] lead;
   reg [6:0] sh;
   wire [23:0] x_lim_word;
   wire [23:0] y_lim_word;
   wire x_lim_flag;
   wire y_lim_flag;
   wire alu_we;
   wire [55:0] keep;

   // accumulator parts, concatenated ext:high:low
   wire [7:0] acc_one_extension = acc_one_q[55:48];
   wire [23:0] acc_one_high = acc_one_q[47:24];
   wire [23:0] acc_one_low = acc_one_q[23:0];
   wire [7:0] acc_two_extension = acc_two_q[55:48];
   wire [23:0] acc_two_high = acc_two_q[47:24];
   wire [23:0] acc_two_low = acc_two_q[23:0];

   ////////////////////////////////////////////////////////////////////
   // operand fetch, widened to the accumulator format
   function [55:0] operand;
      input [2:0] sel;
      input [55:0] one;
      input [55:0] two;
      input [23:0] fh;
      input [23:0] fl;
      input [23:0] sh_;
      input [23:0] sl;
      begin
         case (sel)
            `SRC_FIRST_LO: operand = {{8{fl[23]}}, fl, 24'h000000};
            `SRC_FIRST_HI: operand = {{8{fh[23]}}, fh, 24'h000000};
            `SRC_SECOND_LO: operand = {{8{sl[23]}}, sl, 24'h000000};
            `SRC_SECOND_HI: operand = {{8{sh_[23]}}, sh_, 24'h000000};
            `SRC_ACC_ONE: operand = one;
            `SRC_ACC_TWO: operand = two;
            `SRC_FIRST_L: operand = {{8{fh[23]}}, fh, fl};
            default: operand = {{8{sh_[23]}}, sh_, sl};
         endcase
      end
   endfunction

   // bus read mux; 16-bit words sit in the low bits
   function [23:0] bus_read;
      input [3:0] sel;
      input m16;
      input [23:0] lim_one;
      input [23:0] lim_two;
      input [23:0] fh;
      input [23:0] fl;
      input [23:0] sh_;
      input [23:0] sl;
      input [55:0] one;
      input [55:0] two;
      reg [23:0] w;
      begin
         w = 24'h000000;
         case (sel)
            `SEL_FIRST_LO: w = fl;
            `SEL_FIRST_HI: w = fh;
            `SEL_SECOND_LO: w = sl;
            `SEL_SECOND_HI: w = sh_;
            `SEL_ONE_LOW: w = one[23:0];
            `SEL_ONE_HIGH: w = one[47:24];
            `SEL_ONE_EXT: w = {{16{one[55]}}, one[55:48]};
            `SEL_TWO_LOW: w = two[23:0];
            `SEL_TWO_HIGH: w = two[47:24];
            `SEL_TWO_EXT: w = {{16{two[55]}}, two[55:48]};
            default: w = 24'h000000;
         endcase
         if (sel == `SEL_ONE_LIM) begin
            bus_read = lim_one;
         end else if (sel == `SEL_TWO_LIM) begin
            bus_read = lim_two;
         end else if (m16 && sel != `SEL_ONE_EXT && sel != `SEL_TWO_EXT) begin
            bus_read = {8'h00, w[23:8]};
         end else begin
            bus_read = w;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // one limiter per outgoing bus
   bus_limiter u_x_limiter (
      .acc(x_rd_sel == `SEL_TWO_LIM ? acc_two_q : acc_one_q),
      .scale(scale),
      .mode16(mode16),
      .word(x_lim_word),
      .limited(x_lim_flag)
   );

   bus_limiter u_y_limiter (
      .acc(y_rd_sel == `SEL_TWO_LIM ? acc_two_q : acc_one_q),
      .scale(scale),
      .mode16(mode16),
      .word(y_lim_word),
      .limited(y_lim_flag)
   );

   ////////////////////////////////////////////////////////////////////
   // second stage: multiply, add, shift; a function of stage one and the live mode16
   assign keep = mode16 ? `KEEP16 : `KEEP24;

   always @* begin
      case (s1_sign_q)
         `SGN_SU: prod_full = $signed({s1_opa_q[47], s1_opa_q[47:24]})
            * $signed({1'b0, s1_opb_q[47:24]});
         `SGN_UU: prod_full = $signed({1'b0, s1_opa_q[47:24]})
            * $signed({1'b0, s1_opb_q[47:24]});
         default: prod_full = $signed({s1_opa_q[47], s1_opa_q[47:24]})
            * $signed({s1_opb_q[47], s1_opb_q[47:24]});
      endcase
      // fractional: drop one redundant sign bit, then sign-extend
      prod = {{7{prod_full[47]}}, prod_full[47:0], 1'b0};
      lead = 7'h00;
      begin : lead_count
         integer i;
         reg run;
         run = 1'b1;
         for (i = 55; i >= 0; i = i - 1) begin
            if (run && s1_acc_q[i] == s1_acc_q[55]) begin
               lead = lead + 7'h01;
            end else begin
               run = 1'b0;
            end
         end
      end
      sh = (s1_op_q == `OP_NORM) ? lead - `NORM_LEAD : s1_amt_q;
      res = s1_acc_q;
      case (s1_op_q)
         `OP_MPY: res = prod;
         `OP_MAC: res = s1_acc_q + prod;
         `OP_ADD: res = s1_acc_q + s1_opa_q;
         `OP_SUB: res = s1_acc_q - s1_opa_q;
         `OP_TFR: res = s1_opa_q;
         `OP_AND: res = {s1_acc_q[55:48], s1_acc_q[47:24] & s1_opa_q[47:24],
            s1_acc_q[23:0]};
         `OP_OR: res = {s1_acc_q[55:48], s1_acc_q[47:24] | s1_opa_q[47:24],
            s1_acc_q[23:0]};
         `OP_EOR: res = {s1_acc_q[55:48], s1_acc_q[47:24] ^ s1_opa_q[47:24],
            s1_acc_q[23:0]};
         `OP_ASH, `OP_NORM: begin
            if (sh[6]) begin
               res = $signed(s1_acc_q) >>> (~sh + 7'h01);
            end else begin
               res = s1_acc_q << sh;
            end
         end
         `OP_CLR: res = `ACC_RESET;
         `OP_NEG: res = ~s1_acc_q + 56'h00000000000001;
         `OP_ABS: res = s1_acc_q[55] ? ~s1_acc_q + 56'h00000000000001
            : s1_acc_q;
         default: res = s1_acc_q;
      endcase
      // round the low part of any result but a shift into the high part when asked
      if (s1_round_q && s1_op_q != `OP_ASH && s1_op_q != `OP_NORM) begin
         res = mode16 ? (res + `RND16) & `MASK16
            : (res + `RND24) & `MASK24;
      end
      res = res & keep;
   end

   // condition was sampled at issue; a false one writes nothing
   assign alu_we = s1_valid_q && s1_op_q != `OP_NOP;

   ////////////////////////////////////////////////////////////////////
   // next accumulator values; an alu write beats a bus move
   always @* begin
      acc_one_d = acc_one_q;
      acc_two_d = acc_two_q;
      if (x_wr_en) begin
         case (x_wr_sel)
            `SEL_ONE_LOW: acc_one_d[23:0] = x_wr_data;
            `SEL_ONE_HIGH: acc_one_d[47:24] = x_wr_data;
            `SEL_ONE_EXT: acc_one_d[55:48] = x_wr_data[7:0];
            `SEL_TWO_LOW: acc_two_d[23:0] = x_wr_data;
            `SEL_TWO_HIGH: acc_two_d[47:24] = x_wr_data;
            `SEL_TWO_EXT: acc_two_d[55:48] = x_wr_data[7:0];
            default: acc_one_d = acc_one_d;
         endcase
      end
      if (y_wr_en) begin
         case (y_wr_sel)
            `SEL_ONE_LOW: acc_one_d[23:0] = y_wr_data;
            `SEL_ONE_HIGH: acc_one_d[47:24] = y_wr_data;
            `SEL_ONE_EXT: acc_one_d[55:48] = y_wr_data[7:0];
            `SEL_TWO_LOW: acc_two_d[23:0] = y_wr_data;
            `SEL_TWO_HIGH: acc_two_d[47:24] = y_wr_data;
            `SEL_TWO_EXT: acc_two_d[55:48] = y_wr_data[7:0];
            default: acc_two_d = acc_two_d;
         endcase
      end
      if (alu_we && !s1_dst_q) begin
         acc_one_d = res;
      end
      if (alu_we && s1_dst_q) begin
         acc_two_d = res;
      end
   end

   ////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (rst) begin
         input_reg_first_hi_q <= `REG_RESET;
         input_reg_first_lo_q <= `REG_RESET;
         input_reg_second_hi_q <= `REG_RESET;
         input_reg_second_lo_q <= `REG_RESET;
         acc_one_q <= `ACC_RESET;
         acc_two_q <= `ACC_RESET;
         s1_valid_q <= 1'b0;
         s1_op_q <= `OP_NOP;
         s1_dst_q <= 1'b0;
         s1_round_q <= 1'b0;
         s1_sign_q <= `SGN_SS;
         s1_amt_q <= 7'h00;
         s1_opa_q <= `ACC_RESET;
         s1_opb_q <= `ACC_RESET;
         s1_acc_q <= `ACC_RESET;
         x_rd_data_q <= 24'h000000;
         y_rd_data_q <= 24'h000000;
         x_limited_q <= 1'b0;
         y_limited_q <= 1'b0;
         res_zero_q <= 1'b0;
         res_neg_q <= 1'b0;
      end else begin
         // input registers only ever load from the buses; y wins a tie
         if (x_wr_en && x_wr_sel == `SEL_FIRST_HI) input_reg_first_hi_q <=
            mode16 ? {x_wr_data[15:0], 8'h00} : x_wr_data;
         if (x_wr_en && x_wr_sel == `SEL_FIRST_LO) input_reg_first_lo_q <=
            mode16 ? {x_wr_data[15:0], 8'h00} : x_wr_data;
         if (x_wr_en && x_wr_sel == `SEL_SECOND_HI) input_reg_second_hi_q <=
            mode16 ? {x_wr_data[15:0], 8'h00} : x_wr_data;
         if (x_wr_en && x_wr_sel == `SEL_SECOND_LO) input_reg_second_lo_q <=
            mode16 ? {x_wr_data[15:0], 8'h00} : x_wr_data;
         if (y_wr_en && y_wr_sel == `SEL_FIRST_HI) input_reg_first_hi_q <=
            mode16 ? {y_wr_data[15:0], 8'h00} : y_wr_data;
         if (y_wr_en && y_wr_sel == `SEL_FIRST_LO) input_reg_first_lo_q <=
            mode16 ? {y_wr_data[15:0], 8'h00} : y_wr_data;
         if (y_wr_en && y_wr_sel == `SEL_SECOND_HI) input_reg_second_hi_q <=
            mode16 ? {y_wr_data[15:0], 8'h00} : y_wr_data;
         if (y_wr_en && y_wr_sel == `SEL_SECOND_LO) input_reg_second_lo_q <=
            mode16 ? {y_wr_data[15:0], 8'h00} : y_wr_data;
         acc_one_q <= acc_one_d;
         acc_two_q <= acc_two_d;
         // issue every clock; accumulator operands read from the next-state values
         s1_valid_q <= op_valid && op_cond;
         s1_op_q <= op_code;
         s1_dst_q <= op_dst;
         s1_round_q <= op_round;
         s1_sign_q <= op_sign;
         s1_amt_q <= op_amt;
         s1_opa_q <= operand(op_src1, acc_one_d, acc_two_d,
            input_reg_first_hi_q, input_reg_first_lo_q,
            input_reg_second_hi_q, input_reg_second_lo_q);
         s1_opb_q <= operand(op_src2, acc_one_d, acc_two_d,
            input_reg_first_hi_q, input_reg_first_lo_q,
            input_reg_second_hi_q, input_reg_second_lo_q);
         s1_acc_q <= op_dst ? acc_two_d : acc_one_d;
         // each bus reads its own limiter, which already picked the acc
         x_rd_data_q <= bus_read(x_rd_sel, mode16, x_lim_word, x_lim_word,
            input_reg_first_hi_q, input_reg_first_lo_q,
            input_reg_second_hi_q, input_reg_second_lo_q,
            {acc_one_extension, acc_one_high, acc_one_low},
            {acc_two_extension, acc_two_high, acc_two_low});
         y_rd_data_q <= bus_read(y_rd_sel, mode16, y_lim_word, y_lim_word,
            input_reg_first_hi_q, input_reg_first_lo_q,
            input_reg_second_hi_q, input_reg_second_lo_q,
            {acc_one_extension, acc_one_high, acc_one_low},
            {acc_two_extension, acc_two_high, acc_two_low});
         x_limited_q <= (x_rd_sel == `SEL_ONE_LIM || x_rd_sel == `SEL_TWO_LIM)
            && x_lim_flag;
         y_limited_q <= (y_rd_sel == `SEL_ONE_LIM || y_rd_sel == `SEL_TWO_LIM)
            && y_lim_flag;
         if (alu_we) begin
            res_zero_q <= (res == `ACC_RESET);
            res_neg_q <= res[55];
         end
      end
   end

endmodule // data_alu
`default_nettype wire

// ### data_alu_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "data_alu_defines.vh"
module data_alu_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // mode and issue
   input wire logic mode16,
   input wire logic op_valid,
   input wire logic [3:0] op_code,
   input wire logic op_cond,
   // first bus
   input wire logic x_wr_en,
   input wire logic [3:0] x_wr_sel,
   input wire logic [23:0] x_wr_data,
   input wire logic [3:0] x_rd_sel,
   input wire logic [23:0] x_rd_data_q,
   input wire logic x_limited_q,
   // second bus
   input wire logic y_wr_en,
   input wire logic [3:0] y_rd_sel,
   input wire logic [23:0] y_rd_data_q,
   input wire logic y_limited_q,
   // flags
   input wire logic res_zero_q,
   input wire logic res_neg_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
////////////////////////////////////////////////////////////////////////////
   a_reset_clear: assert property (disable iff (1'b0)
      rst |=> x_rd_data_q == 24'h000000 && !res_zero_q && !res_neg_q)
      else $error("outputs not cleared by reset");
   a_unused_zero: assert property (
      y_rd_sel > 4'hB |=> y_rd_data_q == 24'h000000)
      else $error("unused select did not read zero");
   // write lands on one edge, the read is registered on the next
   a_input_rdback: assert property (
      (x_wr_en && x_wr_sel == `SEL_FIRST_HI && !y_wr_en && !mode16) ##1
      (y_rd_sel == `SEL_FIRST_HI && !mode16)
      |=> y_rd_data_q == $past(x_wr_data, 2))
      else $error("input register not readable on second bus");
   a_lim_code: assert property (
      x_limited_q |-> x_rd_data_q inside {`LIM24_POS, `LIM24_NEG,
      `LIM16_POS, `LIM16_NEG})
      else $error("saturated word is not a limit value");
   a_x_lim_sel: assert property (
      !(x_rd_sel inside {`SEL_ONE_LIM, `SEL_TWO_LIM}) |=> !x_limited_q)
      else $error("first bus limited without limiter select");
   a_y_lim_sel: assert property (
      !(y_rd_sel inside {`SEL_ONE_LIM, `SEL_TWO_LIM}) |=> !y_limited_q)
      else $error("second bus limited without limiter select");
   a_flag_hold: assert property (
      !(op_valid && op_cond) || op_code == `OP_NOP
      |=> ##1 $stable(res_zero_q) && $stable(res_neg_q))
      else $error("flags changed without a written result");
   a_clr_flags: assert property (
      op_valid && op_cond && op_code == `OP_CLR
      |=> ##1 res_zero_q && !res_neg_q)
      else $error("clear did not raise the zero flag");
   // ext parts read sign-extended, so they are left out
   a_mode16_rd: assert property (
      mode16 && !(x_rd_sel inside {`SEL_ONE_EXT, `SEL_TWO_EXT})
      |=> x_rd_data_q[23:16] == 8'h00)
      else $error("16-bit read has upper bits set");
   c_back_to_back: cover property (op_valid && op_code == `OP_MPY ##1
      op_valid && op_code == `OP_MAC);
   c_x_limit: cover property (x_limited_q);
   c_y_limit: cover property (y_limited_q);
   c_cond_off: cover property (op_valid && !op_cond);
endmodule // data_alu_monitor
bind data_alu data_alu_monitor i_data_alu_monitor (.clk, .rst, .mode16,
   .op_valid, .op_code, .op_cond, .x_wr_en, .x_wr_sel, .x_wr_data,
   .x_rd_sel, .x_rd_data_q, .x_limited_q, .y_wr_en, .y_rd_sel,
   .y_rd_data_q, .y_limited_q, .res_zero_q, .res_neg_q);
`default_nettype wire

// ### core_side.sv
`timescale 1ns/100ps
`default_nettype none
module core_side (
   // clock
   input wire logic clk,
   // mode and issue
   output logic mode16,
   output logic [1:0] scale,
   output logic op_valid,
   output logic [3:0] op_code,
   output logic [2:0] op_src1,
   output logic [2:0] op_src2,
   output logic op_dst,
   output logic op_cond,
   output logic op_round,
   output logic [1:0] op_sign,
   output logic [6:0] op_amt,
   // first bus
   output logic x_wr_en,
   output logic [3:0] x_wr_sel,
   output logic [23:0] x_wr_data,
   output logic [3:0] x_rd_sel,
   // second bus
   output logic y_wr_en,
   output logic [3:0] y_wr_sel,
   output logic [23:0] y_wr_data,
   output logic [3:0] y_rd_sel
);
////////////////////////////////////////////////////////////////////////////
   // everything idles at zero until a task drives it
   initial {mode16, scale, op_valid, op_code, op_src1, op_src2, op_dst,
      op_cond, op_round, op_sign, op_amt, x_wr_en, x_wr_sel, x_wr_data,
      x_rd_sel, y_wr_en, y_wr_sel, y_wr_data, y_rd_sel} = '0;
   task automatic mode(input logic m, input logic [1:0] sc = 2'h0,
      input logic r = 1'b0, input logic [1:0] sg = 2'h0);
      @(posedge clk);
      {mode16, scale, op_round, op_sign} <= {m, sc, r, sg};
   endtask
   task automatic wr(input logic xe, input logic [3:0] xs,
      input logic [23:0] xd, input logic ye, input logic [3:0] ys,
      input logic [23:0] yd);
      @(posedge clk);
      op_valid <= 1'b0;
      {x_wr_en, x_wr_sel, x_wr_data} <= {xe, xs, xd};
      {y_wr_en, y_wr_sel, y_wr_data} <= {ye, ys, yd};
   endtask
   task automatic issue(input logic [3:0] c, input logic [2:0] s1,
      input logic [2:0] s2, input logic d, input logic k,
      input logic [6:0] a = 7'h00);
      @(posedge clk);
      {x_wr_en, y_wr_en, op_valid} <= 3'b001;
      {op_code, op_src1, op_src2, op_dst, op_cond, op_amt} <=
         {c, s1, s2, d, k, a};
   endtask
   // two idle edges so a result issued last is seen by the read
   task automatic rd(input logic [3:0] xs, input logic [3:0] ys);
      @(posedge clk);
      {x_wr_en, y_wr_en, op_valid} <= 3'b000;
      {x_rd_sel, y_rd_sel} <= {xs, ys};
      // released data lines toggle instead of holding the last word
      {x_wr_data, y_wr_data} <= ~{x_wr_data, y_wr_data};
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask
endmodule // core_side
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "data_alu_defines.vh"
module tb_top;
   logic clk;
   logic rst;
   wire mode16, op_valid, op_dst, op_cond, op_round;
   wire [1:0] scale, op_sign;
   wire [3:0] op_code, x_wr_sel, x_rd_sel, y_wr_sel, y_rd_sel;
   wire [2:0] op_src1, op_src2;
   wire [6:0] op_amt;
   wire x_wr_en, y_wr_en, x_limited_q, y_limited_q, res_zero_q, res_neg_q;
   wire [23:0] x_wr_data, y_wr_data, x_rd_data_q, y_rd_data_q;
   int n_errors = 0;
   int total_checks = 0;
   typedef struct {
      logic [3:0] sel;
      logic [23:0] data;
      logic [23:0] exp;
   } row_t;
   // ext parts keep only the low byte
   row_t rows [10] = '{
      '{4'h0, 24'h123456, 24'h123456}, '{4'h1, 24'h400000, 24'h400000},
      '{4'h2, 24'h654321, 24'h654321}, '{4'h3, 24'h400000, 24'h400000},
      '{4'h4, 24'h0000AB, 24'h0000AB}, '{4'h5, 24'h000001, 24'h000001},
      '{4'h6, 24'h000015, 24'h000015}, '{4'h7, 24'h111111, 24'h111111},
      '{4'h8, 24'h222222, 24'h222222}, '{4'h9, 24'hABCD00, 24'h000000}};
////////////////////////////////////////////////////////////////////////////
   core_side i_core_side (.clk, .mode16, .scale, .op_valid, .op_code,
      .op_src1, .op_src2, .op_dst, .op_cond, .op_round, .op_sign, .op_amt,
      .x_wr_en, .x_wr_sel, .x_wr_data, .x_rd_sel,
      .y_wr_en, .y_wr_sel, .y_wr_data, .y_rd_sel);
   data_alu i_data_alu (.clk, .rst, .mode16, .scale, .op_valid, .op_code,
      .op_src1, .op_src2, .op_dst, .op_cond, .op_round, .op_sign, .op_amt,
      .x_wr_en, .x_wr_sel, .x_wr_data, .x_rd_sel, .x_rd_data_q,
      .x_limited_q, .y_wr_en, .y_wr_sel, .y_wr_data, .y_rd_sel,
      .y_rd_data_q, .y_limited_q, .res_zero_q, .res_neg_q);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic chk_word(input string name, input logic [23:0] exp,
      input logic [23:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_bit(input string name, input logic exp,
      input logic got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic results;
      if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // the run needs some 93 cycles, so 2000 means a hang
   initial begin
      #200000;
      n_errors++;
      results;
   end
   initial begin
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk_word("read after reset", 24'h000000, x_rd_data_q);
      chk_bit("zero flag after reset", 1'b0, res_zero_q);
      for (int i = 0; i < 10; i++) begin
         i_core_side.wr(1'b1, rows[i].sel, rows[i].data, 1'b0, 4'h0, 24'h0);
         i_core_side.rd(4'h0, rows[i].sel);
         chk_word("read back", rows[i].exp, y_rd_data_q);
      end
      // acc one has a nonzero extension, acc two is in range
      i_core_side.rd(`SEL_ONE_LIM, `SEL_TWO_LIM);
      chk_word("x limited word", `LIM24_POS, x_rd_data_q);
      chk_bit("x limited flag", 1'b1, x_limited_q);
      chk_word("y limiter word", 24'h222222, y_rd_data_q);
      chk_bit("y limited flag", 1'b0, y_limited_q);
      i_core_side.wr(1'b1, 4'h0, 24'hAAAAAA, 1'b1, 4'h0, 24'h555555);
      i_core_side.rd(`SEL_FIRST_LO, 4'hF);
      chk_word("dual write", 24'h555555, x_rd_data_q);
      chk_word("unused select", 24'h000000, y_rd_data_q);
      // sources 1 and 3 hold one half each: product is one quarter
      i_core_side.issue(`OP_MPY, 3'h1, 3'h3, 1'b0, 1'b1);
      i_core_side.issue(`OP_MAC, 3'h1, 3'h3, 1'b0, 1'b1);
      i_core_side.issue(`OP_MAC, 3'h1, 3'h3, 1'b0, 1'b0);
      i_core_side.rd(`SEL_ONE_HIGH, `SEL_ONE_LOW);
      chk_word("mac high", 24'h400000, x_rd_data_q);
      chk_word("mac low", 24'h000000, y_rd_data_q);
      i_core_side.rd(`SEL_ONE_EXT, 4'hF);
      chk_word("mac extension", 24'h000000, x_rd_data_q);
      // acc one and acc two are sources 4 and 5
      i_core_side.issue(`OP_TFR, 3'h4, 3'h4, 1'b1, 1'b1);
      i_core_side.issue(`OP_ASH, 3'h5, 3'h5, 1'b1, 1'b1, 7'h01);
      i_core_side.rd(`SEL_TWO_HIGH, `SEL_TWO_LIM);
      chk_word("shifted high", 24'h800000, x_rd_data_q);
      chk_word("shifted limited", `LIM24_POS, y_rd_data_q);
      chk_bit("shifted limit flag", 1'b1, y_limited_q);
      i_core_side.issue(`OP_CLR, 3'h5, 3'h5, 1'b1, 1'b1);
      i_core_side.rd(`SEL_TWO_HIGH, `SEL_ONE_HIGH);
      chk_word("cleared acc", 24'h000000, x_rd_data_q);
      chk_word("other acc kept", 24'h400000, y_rd_data_q);
      chk_bit("zero flag", 1'b1, res_zero_q);
      // 16-bit mode drops the upper data byte
      i_core_side.mode(1'b1);
      i_core_side.wr(1'b1, 4'h1, 24'hFF1234, 1'b1, 4'h6, 24'h0000F0);
      i_core_side.rd(`SEL_FIRST_HI, `SEL_ONE_LIM);
      chk_word("16-bit input reg", 24'h001234, x_rd_data_q);
      chk_word("16-bit limited", `LIM16_NEG, y_rd_data_q);
      chk_bit("16-bit limit flag", 1'b1, y_limited_q);
      // unsigned product, rounding, limiter scaled down
      i_core_side.mode(1'b0, `SCALE_DOWN, 1'b1, `SGN_UU);
      i_core_side.wr(1'b1, `SEL_FIRST_LO, 24'h800000,
         1'b1, `SEL_SECOND_LO, 24'h000001);
      i_core_side.issue(`OP_MPY, 3'h0, 3'h3, 1'b1, 1'b1);
      i_core_side.issue(`OP_MPY, 3'h2, 3'h3, 1'b0, 1'b1);
      i_core_side.rd(`SEL_TWO_HIGH, `SEL_ONE_HIGH);
      chk_word("unsigned product", 24'h400000, x_rd_data_q);
      chk_word("rounded product", 24'h000001, y_rd_data_q);
      i_core_side.rd(`SEL_TWO_LIM, `SEL_ONE_LOW);
      chk_word("scaled limiter", 24'h200000, x_rd_data_q);
      chk_word("rounded low", 24'h000000, y_rd_data_q);
      i_core_side.issue(`OP_NEG, 3'h5, 3'h5, 1'b1, 1'b1);
      i_core_side.rd(`SEL_TWO_EXT, `SEL_TWO_HIGH);
      chk_word("negated extension", 24'hFFFFFF, x_rd_data_q);
      chk_word("negated high", 24'hC00000, y_rd_data_q);
      chk_bit("negative flag", 1'b1, res_neg_q);
      // reset again in mid-run; everything must clear
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      i_core_side.rd(`SEL_TWO_EXT, `SEL_FIRST_LO);
      chk_word("ext after reset", 24'h000000, x_rd_data_q);
      chk_word("input after reset", 24'h000000, y_rd_data_q);
      chk_bit("negative after reset", 1'b0, res_neg_q);
      results;
   end
endmodule // tb_top
`default_nettype wire
